// File: rtl/act_clock_tree.sv
// audio dac clock tree: root select, cascaded dividers, pin dividers
//
// Behaviour
// - root clock picked by two-bit source field
// - modulator is root over first times second
// - seven-bit divider fields, split ten-bit oversampling
// - dac power-down runs internal shutdown sequence
// - two power flags; disable second then first
// - bit clock pin driven divided when master
// - bit divider input: dsp or modulator clock
// - general-purpose pin drives divided output clock
// - three-bit field picks clock output source
`timescale 1ns/100ps
module act_clock_tree (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // reference clock inputs
    input  wire logic       ref_clk_pin,
    input  wire logic       bit_clock_in,
    input  wire logic       general_purpose_pin_in,
    input  wire logic       pll_clk,
    // pin drivers
    output logic            bit_clock_out,
    output logic            bit_clock_oe,
    output logic            general_purpose_pin_out,
    output logic            general_purpose_pin_oe,
    // dac power
    input  wire logic       dac_power_up,
    output logic            dac_powered,
    // clock enables to the datapath
    output logic            root_audio_clock_tick,
    output logic            dsp_clock_tick,
    output logic            modulator_clock_tick,
    output logic            sample_rate_tick
);

    typedef struct packed {
        logic [7:0]              root_sel;
        logic [7:0]              first_ctl;
        logic [7:0]              second_ctl;
        logic [7:0]              osr_hi;
        logic [7:0]              osr_lo;
        logic [7:0]              cout_sel;
        logic [7:0]              cout_div;
        logic [7:0]              aif_ctl;
        logic [7:0]              bdiv_sel;
        logic [7:0]              bdiv_div;
        logic [7:0]              rdata;
        logic [3:0]              pin_prev;
        logic [3:0]              pin_rise;
        act_pkg::act_pwr_state_t pwr;
        logic [7:0]              step_cnt;
        logic                    dac_flag;
        logic                    mod_flag;
    } act_state_t;

    act_state_t st_reg;
    act_state_t st_next;

    logic [3:0] pins;
    logic       root_tick;
    logic       dsp_tick;
    logic       mod_tick;
    logic       fs_tick;
    logic       bdiv_in;
    logic       cout_in;
    logic       bclk_level;
    logic       cout_level;
    logic [7:0] pwr_status;

    assign pins = {pll_clk, general_purpose_pin_in, bit_clock_in,
                   ref_clk_pin};

    // pin order matches the root select codes
    // the switch is not glitch-free: a tick of the old source and one
    // of the new may land in adjacent cycles
    assign root_tick = st_reg.pin_rise[st_reg.root_sel[1:0]];

    // bit divider source
    // codes 10 and 11 fall back to the dsp clock
    always_comb begin
        case (st_reg.bdiv_sel[1:0])
            act_pkg::BDIV_DSP: bdiv_in = dsp_tick;
            act_pkg::BDIV_MOD: bdiv_in = mod_tick;
            default:           bdiv_in = dsp_tick;
        endcase
    end

    // clock output divider source
    always_comb begin
        case (st_reg.cout_sel[2:0])
            act_pkg::COUT_REF_PIN: cout_in = st_reg.pin_rise[0];
            act_pkg::COUT_BIT_CLK: cout_in = st_reg.pin_rise[1];
            act_pkg::COUT_PLL:     cout_in = st_reg.pin_rise[3];
            act_pkg::COUT_ROOT:    cout_in = root_tick;
            act_pkg::COUT_DSP:     cout_in = dsp_tick;
            act_pkg::COUT_MOD:     cout_in = mod_tick;
            default:               cout_in = root_tick;
        endcase
    end

    // cascade: root -> first -> second -> oversampling
    act_divider #(.W(7)) u_first (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .enable    (st_reg.first_ctl[act_pkg::DIV_EN_BIT]),
        .div_val   (st_reg.first_ctl[6:0]),
        .tick_in   (root_tick),
        .tick_out  (dsp_tick),
        .clk_level ()
    );

    act_divider #(.W(7)) u_second (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .enable    (st_reg.second_ctl[act_pkg::DIV_EN_BIT]),
        .div_val   (st_reg.second_ctl[6:0]),
        .tick_in   (dsp_tick),
        .tick_out  (mod_tick),
        .clk_level ()
    );

    // no enable of its own: it idles whenever the modulator ticks stop
    act_divider #(.W(10)) u_osr (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .enable    (1'b1),
        .div_val   ({st_reg.osr_hi[1:0], st_reg.osr_lo}),
        .tick_in   (mod_tick),
        .tick_out  (fs_tick),
        .clk_level ()
    );

    act_divider #(.W(7)) u_bdiv (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .enable    (st_reg.bdiv_div[act_pkg::DIV_EN_BIT]),
        .div_val   (st_reg.bdiv_div[6:0]),
        .tick_in   (bdiv_in),
        .tick_out  (),
        .clk_level (bclk_level)
    );

    act_divider #(.W(7)) u_cout (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .enable    (st_reg.cout_div[act_pkg::DIV_EN_BIT]),
        .div_val   (st_reg.cout_div[6:0]),
        .tick_in   (cout_in),
        .tick_out  (),
        .clk_level (cout_level)
    );

    // both flags sit at their fixed status bit positions
    always_comb begin
        pwr_status                       = 8'h00;
        pwr_status[act_pkg::PWR_DAC_BIT] = st_reg.dac_flag;
        pwr_status[act_pkg::PWR_MOD_BIT] = st_reg.mod_flag;
    end

    always_comb begin
        st_next          = st_reg;
        st_next.pin_prev = pins;
        // inputs are synchronous, so a plain edge detect suffices
        st_next.pin_rise = pins & ~st_reg.pin_prev;

        if (reg_wr) begin
            case (reg_addr)
                act_pkg::ADDR_ROOT_SRC:
                    st_next.root_sel = reg_wdata & act_pkg::MASK_ROOT_SRC;
                act_pkg::ADDR_FIRST_DIV:
                    st_next.first_ctl = reg_wdata & act_pkg::MASK_DIV;
                act_pkg::ADDR_SECOND_DIV:
                    st_next.second_ctl = reg_wdata & act_pkg::MASK_DIV;
                act_pkg::ADDR_OSR_HIGH:
                    st_next.osr_hi = reg_wdata & act_pkg::MASK_OSR_HIGH;
                act_pkg::ADDR_OSR_LOW:
                    st_next.osr_lo = reg_wdata & act_pkg::MASK_OSR_LOW;
                act_pkg::ADDR_COUT_SRC:
                    st_next.cout_sel = reg_wdata & act_pkg::MASK_COUT_SRC;
                act_pkg::ADDR_COUT_DIV:
                    st_next.cout_div = reg_wdata & act_pkg::MASK_DIV;
                act_pkg::ADDR_AIF_CTL:
                    st_next.aif_ctl = reg_wdata & act_pkg::MASK_AIF_CTL;
                act_pkg::ADDR_BDIV_SRC:
                    st_next.bdiv_sel = reg_wdata & act_pkg::MASK_BDIV_SRC;
                act_pkg::ADDR_BDIV_DIV:
                    st_next.bdiv_div = reg_wdata & act_pkg::MASK_DIV;
                default: ;
            endcase
        end

        // a read in the cycle of a write returns the old value
        if (reg_rd) begin
            case (reg_addr)
                act_pkg::ADDR_ROOT_SRC:   st_next.rdata = st_reg.root_sel;
                act_pkg::ADDR_FIRST_DIV:  st_next.rdata = st_reg.first_ctl;
                act_pkg::ADDR_SECOND_DIV: st_next.rdata = st_reg.second_ctl;
                act_pkg::ADDR_OSR_HIGH:   st_next.rdata = st_reg.osr_hi;
                act_pkg::ADDR_OSR_LOW:    st_next.rdata = st_reg.osr_lo;
                act_pkg::ADDR_COUT_SRC:   st_next.rdata = st_reg.cout_sel;
                act_pkg::ADDR_COUT_DIV:   st_next.rdata = st_reg.cout_div;
                act_pkg::ADDR_AIF_CTL:    st_next.rdata = st_reg.aif_ctl;
                act_pkg::ADDR_BDIV_SRC:   st_next.rdata = st_reg.bdiv_sel;
                act_pkg::ADDR_BDIV_DIV:   st_next.rdata = st_reg.bdiv_div;
                act_pkg::ADDR_PWR_STAT:   st_next.rdata = pwr_status;
                default:                  st_next.rdata = 8'h00;
            endcase
        end

        // steps advance on modulator ticks only: if software stops the
        // dividers mid-sequence the dac stalls instead of shutting down
        if (mod_tick) begin
            st_next.step_cnt = st_reg.step_cnt + 8'h01;
        end
        case (st_reg.pwr)
            act_pkg::PWR_OFF: begin
                st_next.step_cnt = 8'h00;
                if (dac_power_up) begin
                    st_next.pwr = act_pkg::PWR_RISE;
                end
            end
            act_pkg::PWR_RISE: begin
                if (!dac_power_up) begin
                    st_next.pwr      = act_pkg::PWR_FALL;
                    st_next.step_cnt = 8'h00;
                end else if (st_reg.step_cnt >= act_pkg::PWR_UP_STEPS) begin
                    st_next.pwr      = act_pkg::PWR_ON;
                    st_next.dac_flag = 1'b1;
                    st_next.mod_flag = 1'b1;
                end
            end
            act_pkg::PWR_ON: begin
                st_next.step_cnt = 8'h00;
                if (!dac_power_up) begin
                    st_next.pwr = act_pkg::PWR_FALL;
                end
            end
            act_pkg::PWR_FALL: begin
                if (st_reg.step_cnt >= act_pkg::PWR_MOD_OFF_AT) begin
                    st_next.mod_flag = 1'b0;
                end
                if (st_reg.step_cnt >= act_pkg::PWR_DOWN_STEPS) begin
                    st_next.pwr      = act_pkg::PWR_OFF;
                    st_next.dac_flag = 1'b0;
                    st_next.mod_flag = 1'b0;
                end
            end
            default: begin
                st_next.pwr = act_pkg::PWR_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg            <= '0;
            st_reg.root_sel   <= act_pkg::RST_ROOT_SRC;
            st_reg.first_ctl  <= act_pkg::RST_FIRST_DIV;
            st_reg.second_ctl <= act_pkg::RST_SECOND_DIV;
            st_reg.osr_hi     <= act_pkg::RST_OSR_HIGH;
            st_reg.osr_lo     <= act_pkg::RST_OSR_LOW;
            st_reg.cout_sel   <= act_pkg::RST_COUT_SRC;
            st_reg.cout_div   <= act_pkg::RST_COUT_DIV;
            st_reg.aif_ctl    <= act_pkg::RST_AIF_CTL;
            st_reg.bdiv_sel   <= act_pkg::RST_BDIV_SRC;
            st_reg.bdiv_div   <= act_pkg::RST_BDIV_DIV;
            st_reg.pwr        <= act_pkg::PWR_OFF;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;

    // pin drivers follow divider levels, which are flip-flops
    assign bit_clock_oe  = st_reg.aif_ctl[act_pkg::BCLK_MASTER_BIT];
    assign bit_clock_out = bclk_level & bit_clock_oe;
    // the gp pin is claimed whenever its divider is enabled
    assign general_purpose_pin_oe  = st_reg.cout_div[act_pkg::DIV_EN_BIT];
    assign general_purpose_pin_out = cout_level;

    assign dac_powered           = st_reg.dac_flag;
    assign root_audio_clock_tick = root_tick;
    assign dsp_clock_tick        = dsp_tick;
    assign modulator_clock_tick  = mod_tick;
    assign sample_rate_tick      = fs_tick;

endmodule // act_clock_tree

// File: pkg/act_pkg.sv
// constants and types shared by the audio clock tree
package act_pkg;

    // register offsets
    localparam logic [7:0] ADDR_ROOT_SRC   = 8'h04;
    localparam logic [7:0] ADDR_FIRST_DIV  = 8'h0b;
    localparam logic [7:0] ADDR_SECOND_DIV = 8'h0c;
    localparam logic [7:0] ADDR_OSR_HIGH   = 8'h0d;
    localparam logic [7:0] ADDR_OSR_LOW    = 8'h0e;
    localparam logic [7:0] ADDR_COUT_SRC   = 8'h19;
    localparam logic [7:0] ADDR_COUT_DIV   = 8'h1a;
    localparam logic [7:0] ADDR_AIF_CTL    = 8'h1b;
    localparam logic [7:0] ADDR_BDIV_SRC   = 8'h1d;
    localparam logic [7:0] ADDR_BDIV_DIV   = 8'h1e;
    localparam logic [7:0] ADDR_PWR_STAT   = 8'h25;

    // writable bits of each register, the rest read as zero
    localparam logic [7:0] MASK_ROOT_SRC   = 8'h03;
    localparam logic [7:0] MASK_DIV        = 8'hff;
    localparam logic [7:0] MASK_OSR_HIGH   = 8'h03;
    localparam logic [7:0] MASK_OSR_LOW    = 8'hff;
    localparam logic [7:0] MASK_COUT_SRC   = 8'h07;
    localparam logic [7:0] MASK_AIF_CTL    = 8'hff;
    localparam logic [7:0] MASK_BDIV_SRC   = 8'h03;

    // field positions
    localparam int DIV_EN_BIT       = 7;
    localparam int BCLK_MASTER_BIT  = 3;
    localparam int PWR_DAC_BIT      = 7;
    localparam int PWR_MOD_BIT      = 3;

    // reset values
    localparam logic [7:0] RST_ROOT_SRC   = 8'h00;
    localparam logic [7:0] RST_FIRST_DIV  = 8'h01;
    localparam logic [7:0] RST_SECOND_DIV = 8'h01;
    localparam logic [7:0] RST_OSR_HIGH   = 8'h00;
    localparam logic [7:0] RST_OSR_LOW    = 8'h80;
    localparam logic [7:0] RST_COUT_SRC   = 8'h00;
    localparam logic [7:0] RST_COUT_DIV   = 8'h01;
    localparam logic [7:0] RST_AIF_CTL    = 8'h00;
    localparam logic [7:0] RST_BDIV_SRC   = 8'h00;
    localparam logic [7:0] RST_BDIV_DIV   = 8'h01;

    // root source codes
    localparam logic [1:0] ROOT_REF_PIN = 2'h0;
    localparam logic [1:0] ROOT_BIT_CLK = 2'h1;
    localparam logic [1:0] ROOT_GP_PIN  = 2'h2;
    localparam logic [1:0] ROOT_PLL     = 2'h3;

    // bit divider source codes
    localparam logic [1:0] BDIV_DSP     = 2'h0;
    localparam logic [1:0] BDIV_MOD     = 2'h1;

    // clock output divider source codes
    localparam logic [2:0] COUT_REF_PIN = 3'h0;
    localparam logic [2:0] COUT_BIT_CLK = 3'h1;
    localparam logic [2:0] COUT_PLL     = 3'h2;
    localparam logic [2:0] COUT_ROOT    = 3'h3;
    localparam logic [2:0] COUT_DSP     = 3'h4;
    localparam logic [2:0] COUT_MOD     = 3'h5;

    // power sequencing, counted in modulator clock ticks
    localparam logic [7:0] PWR_UP_STEPS   = 8'h08;
    localparam logic [7:0] PWR_DOWN_STEPS = 8'h10;
    localparam logic [7:0] PWR_MOD_OFF_AT = 8'h08;

    typedef enum logic [1:0] {
        PWR_OFF  = 2'b00,
        PWR_RISE = 2'b01,
        PWR_ON   = 2'b10,
        PWR_FALL = 2'b11
    } act_pwr_state_t;

endpackage

// File: rtl/act_divider.sv
// programmable tick divider with a square-wave level output
`timescale 1ns/100ps
module act_divider #(
    parameter int W = 7
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rst,
    // control
    input  wire logic         enable,
    input  wire logic [W-1:0] div_val,
    // ticks
    input  wire logic         tick_in,
    output logic              tick_out,
    output logic              clk_level
);

    typedef struct packed {
        logic [W:0] cnt;
        logic       tick;
        logic       level;
    } act_div_state_t;

    act_div_state_t st_reg;
    act_div_state_t st_next;

    // all-zeros code means the largest ratio
    function automatic logic [W:0] ratio(input logic [W-1:0] v);
        ratio = (v == '0) ? (W+1)'(1 << W) : {1'b0, v};
    endfunction

    logic [W:0] n;
    logic [W:0] half;

    assign n    = ratio(div_val);
    assign half = (W+1)'((n + (W+1)'(1)) >> 1);

    always_comb begin
        st_next      = st_reg;
        st_next.tick = 1'b0;
        if (!enable) begin
            st_next.cnt   = '0;
            st_next.level = 1'b0;
        end else begin
            if (tick_in) begin
                if (st_reg.cnt >= n - (W+1)'(1)) begin
                    st_next.cnt  = '0;
                    st_next.tick = 1'b1;
                end else begin
                    st_next.cnt = st_reg.cnt + (W+1)'(1);
                end
            end
            // divide by one cannot toggle at sys_clk rate: level stays high
            st_next.level = (st_next.cnt < half);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_out  = st_reg.tick;
    assign clk_level = st_reg.level;

endmodule // act_divider

// File: testbench/act_ref_source_model.sv
// model of the reference clock sources facing the clock tree
`timescale 1ns/100ps
module act_ref_source_model #(
    parameter int HALF_REF = 2,
    parameter int HALF_BIT = 3,
    parameter int HALF_GP  = 4,
    parameter int HALF_PLL = 1
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // source levels
    output logic      ref_clk,
    output logic      bit_clk,
    output logic      gp_clk,
    output logic      pll_out
);
    localparam int HALF [4] = '{HALF_REF, HALF_BIT, HALF_GP, HALF_PLL};
    logic [3:0] lvl_reg;
    int         cnt_reg [4];

    // each source toggles every HALF cycles, so all stay below the
    // sampling limit of the tree and inside the rate caps
    // the pll output runs from reset on, so it is up before and
    // after every clock that depends on it
    always_ff @(posedge sys_clk or posedge rst) begin
        for (int i = 0; i < 4; i++) begin
            if (rst) begin
                lvl_reg[i] <= 1'b0;
                cnt_reg[i] <= 0;
            end else if (cnt_reg[i] == HALF[i] - 1) begin
                lvl_reg[i] <= ~lvl_reg[i];
                cnt_reg[i] <= 0;
            end else begin
                cnt_reg[i] <= cnt_reg[i] + 1;
            end
        end
    end

    assign ref_clk = lvl_reg[0];
    assign bit_clk = lvl_reg[1];
    assign gp_clk  = lvl_reg[2];
    assign pll_out = lvl_reg[3];
endmodule // act_ref_source_model

// File: testbench/act_clock_tree_sva.sv
// port assertions for the audio clock tree
`timescale 1ns/100ps
module act_clock_tree_sva (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // pins and power
    input wire logic       bit_clock_oe,
    input wire logic       general_purpose_pin_oe,
    input wire logic       dac_power_up,
    input wire logic       dac_powered,
    // ticks
    input wire logic       root_audio_clock_tick,
    input wire logic       dsp_clock_tick,
    input wire logic       modulator_clock_tick,
    input wire logic       sample_rate_tick
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_root_single: assert property (
        root_audio_clock_tick &&
        !(reg_wr && reg_addr == act_pkg::ADDR_ROOT_SRC) |=>
        !root_audio_clock_tick)
        else $error("root tick longer than one cycle");
    a_dsp_from_root: assert property (
        dsp_clock_tick |-> $past(root_audio_clock_tick))
        else $error("dsp tick without root tick");
    a_mod_from_dsp: assert property (
        modulator_clock_tick |-> $past(dsp_clock_tick))
        else $error("modulator tick without dsp tick");
    a_fs_from_mod: assert property (
        sample_rate_tick |-> $past(modulator_clock_tick))
        else $error("sample tick without modulator tick");
    a_bclk_oe_follow: assert property (
        reg_wr && reg_addr == act_pkg::ADDR_AIF_CTL ##2 1'b1 |->
        bit_clock_oe == $past(reg_wdata[act_pkg::BCLK_MASTER_BIT], 2))
        else $error("bit clock enable does not follow master bit");
    a_gp_oe_follow: assert property (
        reg_wr && reg_addr == act_pkg::ADDR_COUT_DIV |-> ##2
        general_purpose_pin_oe == $past(reg_wdata[7], 2))
        else $error("gp pin enable does not follow divider enable");
    a_power_needs_req: assert property (
        $rose(dac_powered) |-> $past(dac_power_up))
        else $error("dac powered without request");
    a_shutdown_gradual: assert property (
        $fell(dac_power_up) && dac_powered |=> dac_powered [*8])
        else $error("dac dropped power abruptly");
    a_rdata_holds: assert property (
        !$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_div_off_quiet: assert property (
        reg_wr && reg_addr == act_pkg::ADDR_FIRST_DIV &&
        !reg_wdata[act_pkg::DIV_EN_BIT] |=> ##1 !dsp_clock_tick [*8])
        else $error("dsp ticks while first divider disabled");

    c_powered: cover property ($rose(dac_powered));
    c_shutdown: cover property ($fell(dac_powered));
    c_sample: cover property (sample_rate_tick);
endmodule // act_clock_tree_sva

bind act_clock_tree act_clock_tree_sva u_sva (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bit_clock_oe(bit_clock_oe),
    .general_purpose_pin_oe(general_purpose_pin_oe),
    .dac_power_up(dac_power_up), .dac_powered(dac_powered),
    .root_audio_clock_tick(root_audio_clock_tick),
    .dsp_clock_tick(dsp_clock_tick),
    .modulator_clock_tick(modulator_clock_tick),
    .sample_rate_tick(sample_rate_tick)
);

// File: testbench/tb_top.sv
// self-checking testbench for the audio clock tree
`timescale 1ns/100ps
module tb_top;
    logic       sys_clk, rst, reg_wr, reg_rd, dac_power_up, dac_powered;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       ref_clk_pin, ext_bit, ext_gp, pll_clk, bit_in, gp_in;
    logic       bit_out, bit_oe, gp_out, gp_oe;
    logic       root_tick, dsp_tick, mod_tick, fs_tick;
    int         num_errors = 0, tests_run = 0, mod_cnt = 0, dsp_cnt = 0;
    int         p, t0;
    localparam logic [7:0] RADDR [11] = '{8'h04, 8'h0b, 8'h0c, 8'h0d,
        8'h0e, 8'h19, 8'h1a, 8'h1b, 8'h1d, 8'h1e, 8'h25};
    localparam logic [7:0] RRST [11] = '{8'h00, 8'h01, 8'h01, 8'h00,
        8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 8'h01, 8'h00};
    localparam logic [7:0] MADDR [4] = '{8'h04, 8'h0d, 8'h19, 8'h1d};
    localparam logic [7:0] MEXP [4] = '{8'h03, 8'h03, 8'h07, 8'h03};
    localparam int ROOT_PER [4] = '{4, 6, 8, 2};
    localparam int COUT_PER [8] = '{4, 6, 2, 2, 6, 12, 2, 2};

    // shared pins: whoever drives sets the level seen by the tree
    assign bit_in = bit_oe ? bit_out : ext_bit;
    assign gp_in  = gp_oe ? gp_out : ext_gp;

    act_clock_tree DUT (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ref_clk_pin(ref_clk_pin),
        .bit_clock_in(bit_in), .general_purpose_pin_in(gp_in),
        .pll_clk(pll_clk), .bit_clock_out(bit_out), .bit_clock_oe(bit_oe),
        .general_purpose_pin_out(gp_out), .general_purpose_pin_oe(gp_oe),
        .dac_power_up(dac_power_up), .dac_powered(dac_powered),
        .root_audio_clock_tick(root_tick), .dsp_clock_tick(dsp_tick),
        .modulator_clock_tick(mod_tick), .sample_rate_tick(fs_tick));

    act_ref_source_model u_src (
        .sys_clk(sys_clk), .rst(rst), .ref_clk(ref_clk_pin),
        .bit_clk(ext_bit), .gp_clk(ext_gp), .pll_out(pll_clk));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk) begin
        if (mod_tick === 1'b1) mod_cnt++;
        if (dsp_tick === 1'b1) dsp_cnt++;
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        check("reg_rdata", {24'h0, reg_rdata}, {24'h0, exp});
    endtask

    function automatic logic sig(input int w);
        case (w)
            0: return root_tick;
            1: return dsp_tick;
            2: return mod_tick;
            3: return fs_tick;
            4: return bit_out;
            default: return gp_out;
        endcase
    endfunction

    // skips the first rise so a count left over from before is ignored
    task automatic period(input int w, output int per);
        int k, n;
        logic pv;
        k = 0;
        per = 0;
        pv = sig(w);
        for (n = 0; n < 10000 && k < 3; n++) begin
            @(negedge sys_clk);
            if (sig(w) === 1'b1 && pv === 1'b0) k++;
            pv = sig(w);
            if (k == 2) per++;
        end
    endtask

    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #6_000_000;
        num_errors++;
        summarize;
    end

    initial begin
        {rst, reg_wr, reg_rd, dac_power_up} = 4'b1000;
        {reg_addr, reg_wdata} = 16'h0000;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 11; i++) rd_check(RADDR[i], RRST[i]);
        rd_check(8'h05, 8'h00);
        wr(act_pkg::ADDR_PWR_STAT, 8'hff);
        rd_check(act_pkg::ADDR_PWR_STAT, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(MADDR[i], 8'hff);
            rd_check(MADDR[i], MEXP[i]);
        end
        wr(act_pkg::ADDR_BDIV_SRC, 8'h00);
        wr(act_pkg::ADDR_FIRST_DIV, 8'h81);
        wr(act_pkg::ADDR_SECOND_DIV, 8'h81);
        for (int i = 0; i < 4; i++) begin
            wr(act_pkg::ADDR_ROOT_SRC, 8'(i));
            period(0, p);
            check("root period", p, ROOT_PER[i]);
        end
        wr(act_pkg::ADDR_OSR_HIGH, 8'h01);
        wr(act_pkg::ADDR_OSR_LOW, 8'h00);
        period(3, p);
        check("sample period split", p, 512);
        wr(act_pkg::ADDR_OSR_HIGH, 8'h00);
        period(3, p);
        check("sample period zero", p, 2048);
        wr(act_pkg::ADDR_FIRST_DIV, 8'h80);
        period(1, p);
        check("dsp period zero", p, 256);
        wr(act_pkg::ADDR_FIRST_DIV, 8'h83);
        wr(act_pkg::ADDR_SECOND_DIV, 8'h82);
        wr(act_pkg::ADDR_OSR_LOW, 8'h04);
        period(1, p);
        check("dsp period", p, 6);
        period(2, p);
        check("modulator period", p, 12);
        period(3, p);
        check("sample period", p, 48);
        wr(act_pkg::ADDR_AIF_CTL, 8'h08);
        wr(act_pkg::ADDR_BDIV_DIV, 8'h85);
        period(4, p);
        check("bit clock dsp", p, 30);
        check("bit clock oe", {31'h0, bit_oe}, 1);
        wr(act_pkg::ADDR_BDIV_SRC, 8'h01);
        period(4, p);
        check("bit clock mod", p, 60);
        wr(act_pkg::ADDR_BDIV_SRC, 8'h02);
        period(4, p);
        check("bit clock fallback", p, 30);
        wr(act_pkg::ADDR_AIF_CTL, 8'h00);
        repeat (3) @(negedge sys_clk);
        check("bit clock oe off", {31'h0, bit_oe}, 0);
        wr(act_pkg::ADDR_COUT_DIV, 8'h84);
        for (int i = 0; i < 8; i++) begin
            wr(act_pkg::ADDR_COUT_SRC, 8'(i));
            period(5, p);
            check("gp clock", p, 4 * COUT_PER[i]);
        end
        check("gp oe", {31'h0, gp_oe}, 1);
        @(posedge sys_clk);
        dac_power_up <= 1'b1;
        t0 = mod_cnt;
        for (int n = 0; n < 3000 && dac_powered !== 1'b1; n++)
            @(negedge sys_clk);
        check("power up ticks", mod_cnt - t0 >= 8, 1);
        rd_check(act_pkg::ADDR_PWR_STAT, 8'h88);
        @(posedge sys_clk);
        dac_power_up <= 1'b0;
        t0 = mod_cnt;
        for (int n = 0; n < 3000 && mod_cnt - t0 < 10; n++)
            @(negedge sys_clk);
        rd_check(act_pkg::ADDR_PWR_STAT, 8'h80);
        for (int n = 0; n < 3000 && dac_powered !== 1'b0; n++)
            @(negedge sys_clk);
        check("shutdown ticks", mod_cnt - t0 >= 16, 1);
        rd_check(act_pkg::ADDR_PWR_STAT, 8'h00);
        wr(act_pkg::ADDR_SECOND_DIV, 8'h02);
        wr(act_pkg::ADDR_FIRST_DIV, 8'h03);
        // a tick launched on the write edge may still show once
        repeat (2) @(negedge sys_clk);
        t0 = dsp_cnt;
        repeat (40) @(negedge sys_clk);
        check("dsp ticks off", dsp_cnt - t0, 0);
        summarize;
    end
endmodule // tb_top
